// *** include/xtc_pkg.sv ***
// ****************************************
// Package for the crystal trim and clock output block
// ****************************************
package xtc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    // Offsets 0x03, 0x13, 0x61 are not multiples of four, so each
    // offset is an index and the byte address is four times it
    localparam logic [7:0] IDX_CLK_MODE = 8'h02;
    localparam logic [7:0] IDX_TRIM_MODE = 8'h03;
    localparam logic [7:0] IDX_DIV_LOW = 8'h13;
    localparam logic [7:0] IDX_DIV_MID = 8'h14;
    localparam logic [7:0] IDX_DIV_HIGH = 8'h15;
    localparam logic [7:0] IDX_TRIM_COARSE = 8'h61;
    localparam logic [7:0] IDX_TRIM_FINE = 8'h62;
    // Status and run-mode control, placed in otherwise unused indices
    localparam logic [7:0] IDX_RUN_CTRL = 8'h70;
    localparam logic [7:0] IDX_STATUS = 8'h71;

    // ****************************************
    // Field positions and widths
    // ****************************************
    localparam int CLK_EN_BIT = 6;
    localparam int TRIM_EN_BIT = 4;
    localparam int COARSE_W = 5;
    localparam int FINE_W = 4;
    localparam int DIV_W = 20;
    localparam int HIGH_W = 4;
    localparam int RUN_BIT = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_CLK_MODE = 8'h40;
    localparam logic [7:0] RST_TRIM_MODE = 8'h00;
    localparam logic [7:0] RST_DIV_LOW = 8'h07;
    localparam logic [7:0] RST_DIV_MID = 8'h00;
    localparam logic [3:0] RST_DIV_HIGH = 4'h0;
    localparam logic [4:0] RST_COARSE = 5'h10;
    localparam logic [3:0] RST_FINE = 4'h0;

    // ****************************************
    // AXI4-Lite response codes
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Trim switch bundle driven onto the capacitor banks
    typedef struct packed {
        logic [4:0] coarse;
        logic [3:0] fine;
    } xtc_switch_type;

endpackage

// *** hdl/xtc_trim_clkout.sv ***
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// ****************************************
// Crystal trim switch control and divided clock output
// ****************************************
// Operation
// - Sleep opens every trim switch unless trim is enabled
// - Leaving sleep loads stored trim bits
// - Run-mode trim writes apply only if enabled
// - Trim enable is bit 4 at 0x03
// - Trim enable keeps capacitors during sleep
// - Coarse trim at 0x61, reset 0x10
// - Fine trim at 0x62, reset zero
// - Clock output enable is bit 6 at 0x02
// - Twenty-bit counter then divide-by-two toggle
// - Output is clock over twice factor
// - Factor low and mid bytes at 0x13/0x14
// - Factor top nibble at 0x15
// - After reset clock output runs, factor 7
module xtc_trim_clkout
    import xtc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Trim capacitor switches, high closes a switch
    output xtc_switch_type trim_switch,
    // Divided clock pin
    output logic divided_clock_pin
);

    // ****************************************
    // Local state
    // ****************************************
    logic [7:0] clock_output_mode_control_reg; // Clock output mode
    logic [7:0] trim_mode_control_reg; // Trim enable lives here
    logic [7:0] out_divider_low_byte_reg; // Factor bits 7:0
    logic [7:0] out_divider_mid_byte_reg; // Factor bits 15:8
    logic [3:0] out_divider_high_nibble_reg; // Factor bits 19:16
    logic [4:0] crystal_trim_coarse_reg; // Stored coarse bits
    logic [3:0] crystal_trim_fine_reg; // Stored fine bits
    logic run_mode_reg; // High in run, low in sleep
    logic run_mode_d_reg; // Previous run flag for edge
    xtc_switch_type trim_switch_reg; // Active switch pattern
    logic [DIV_W-1:0] div_count_reg; // Division counter
    logic clk_toggle_reg; // Divide-by-two stage
    // Bus capture
    logic aw_held_reg; // Write address captured
    logic w_held_reg; // Write data captured
    // Readies are registered so every port leaves straight from a flop
    logic aw_ready_reg; // Address channel free
    logic w_ready_reg; // Data channel free
    logic ar_ready_reg; // Read address channel free
    logic [31:0] awaddr_reg; // Captured write address
    logic [31:0] wdata_reg; // Captured write data
    logic [3:0] wstrb_reg; // Captured byte enables
    logic bvalid_reg; // Write response pending
    logic [1:0] bresp_reg; // Write response code
    logic rvalid_reg; // Read response pending
    logic [1:0] rresp_reg; // Read response code
    logic [31:0] rdata_reg; // Read data
    logic do_write; // One-cycle write commit
    logic [DIV_W-1:0] div_factor; // Assembled factor
    logic trim_en; // Trim enable bit
    logic clk_en; // Clock output enable bit

    // ****************************************
    // Helpers
    // ****************************************
    // Word address to register index; the check on bits 31:10 in addr_valid rejects aliases
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction

    function automatic logic addr_valid(input logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        addr_valid = (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0) &&
            (idx == IDX_CLK_MODE || idx == IDX_TRIM_MODE || idx == IDX_DIV_LOW ||
             idx == IDX_DIV_MID || idx == IDX_DIV_HIGH || idx == IDX_TRIM_COARSE ||
             idx == IDX_TRIM_FINE || idx == IDX_RUN_CTRL || idx == IDX_STATUS);
    endfunction

    assign trim_en = trim_mode_control_reg[TRIM_EN_BIT];
    assign clk_en = clock_output_mode_control_reg[CLK_EN_BIT];
    assign div_factor = {out_divider_high_nibble_reg, out_divider_mid_byte_reg,
        out_divider_low_byte_reg};
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data taken in either order, response after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            aw_ready_reg <= 1'b1;
            w_ready_reg <= 1'b1;
        end
        else
        begin
            // Capture address when free
            if (s_axi_awvalid && !aw_held_reg)
            begin
                aw_held_reg <= 1'b1;
                aw_ready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            // Capture data when free
            if (s_axi_wvalid && !w_held_reg)
            begin
                w_held_reg <= 1'b1;
                w_ready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            // Commit and answer
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                aw_ready_reg <= 1'b1;
                w_ready_reg <= 1'b1;
                bvalid_reg <= 1'b1;
                // Status index is read-only, so a write there is refused
                bresp_reg <= (addr_valid(awaddr_reg) && reg_index(awaddr_reg) != IDX_STATUS)
                    ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_awready = aw_ready_reg;
    assign s_axi_wready = w_ready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ****************************************
    // Configuration registers
    // ****************************************
    // Only byte lane 0 carries data; other lanes are ignored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clock_output_mode_control_reg <= RST_CLK_MODE;
            trim_mode_control_reg <= RST_TRIM_MODE;
            out_divider_low_byte_reg <= RST_DIV_LOW;
            out_divider_mid_byte_reg <= RST_DIV_MID;
            out_divider_high_nibble_reg <= RST_DIV_HIGH;
            crystal_trim_coarse_reg <= RST_COARSE;
            crystal_trim_fine_reg <= RST_FINE;
            run_mode_reg <= 1'b0;
        end
        // Refused addresses store nothing, else a misaligned alias would land
        else if (do_write && wstrb_reg[0] && addr_valid(awaddr_reg))
        begin
            unique case (reg_index(awaddr_reg))
                IDX_CLK_MODE: clock_output_mode_control_reg <= wdata_reg[7:0];
                IDX_TRIM_MODE: trim_mode_control_reg <= wdata_reg[7:0];
                IDX_DIV_LOW: out_divider_low_byte_reg <= wdata_reg[7:0];
                IDX_DIV_MID: out_divider_mid_byte_reg <= wdata_reg[7:0];
                IDX_DIV_HIGH: out_divider_high_nibble_reg <= wdata_reg[HIGH_W-1:0];
                IDX_TRIM_COARSE: crystal_trim_coarse_reg <= wdata_reg[COARSE_W-1:0];
                IDX_TRIM_FINE: crystal_trim_fine_reg <= wdata_reg[FINE_W-1:0];
                // Mode selection stands in for the master control unit
                IDX_RUN_CTRL: run_mode_reg <= wdata_reg[RUN_BIT];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    // Configuration is write-only and reads zero except run control, which reads its flag; status shows state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            ar_ready_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end
        else if (!rvalid_reg && s_axi_arvalid)
        begin
            rvalid_reg <= 1'b1;
            ar_ready_reg <= 1'b0;
            rresp_reg <= addr_valid(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (addr_valid(s_axi_araddr) && reg_index(s_axi_araddr) == IDX_STATUS)
            begin
                // Active switches, output level and run flag
                rdata_reg <= {21'h0, trim_switch_reg, clk_toggle_reg, run_mode_reg};
            end
            else if (addr_valid(s_axi_araddr) && reg_index(s_axi_araddr) == IDX_RUN_CTRL)
            begin
                rdata_reg <= {31'h0, run_mode_reg};
            end
            else
            begin
                rdata_reg <= 32'h0;
            end
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_reg <= 1'b0;
            ar_ready_reg <= 1'b1;
        end
    end

    assign s_axi_arready = ar_ready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ****************************************
    // Trim switch control
    // ****************************************
    // Active pattern is held apart from the stored bits so run-mode
    // writes stay invisible until trimming is enabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_mode_d_reg <= 1'b0;
            trim_switch_reg <= '0;
        end
        else
        begin
            run_mode_d_reg <= run_mode_reg;
            if (!run_mode_reg)
            begin
                if (!trim_en)
                begin
                    trim_switch_reg <= '0;
                end
            end
            else if (!run_mode_d_reg || trim_en)
            begin
                // sample stored bits on leaving sleep
                trim_switch_reg <= '{coarse: crystal_trim_coarse_reg,
                    fine: crystal_trim_fine_reg};
            end
        end
    end

    assign trim_switch = trim_switch_reg;

    // ****************************************
    // Clock output divider
    // ****************************************
    // Counting down to one avoids a compare against the live factor,
    // so a new factor only lands at the reload
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_count_reg <= DIV_W'(RST_DIV_LOW);
            clk_toggle_reg <= 1'b0;
        end
        else if (!clk_en)
        begin
            div_count_reg <= div_factor;
            clk_toggle_reg <= 1'b0;
        end
        else if (div_count_reg == DIV_W'(1))
        begin
            // zero factor wraps to 2^20 counts
            div_count_reg <= div_factor;
            clk_toggle_reg <= !clk_toggle_reg;
        end
        else
        begin
            div_count_reg <= div_count_reg - DIV_W'(1);
        end
    end

    assign divided_clock_pin = clk_toggle_reg;

endmodule // xtc_trim_clkout

// *** tb/xtc_trim_clkout_checker.sv ***
`timescale 1ns/1ps
// ****************************************
// Port checker for trim and clock output
// ****************************************
module xtc_trim_clkout_checker
    import xtc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Watched outputs
    input wire xtc_switch_type trim_switch,
    input wire logic divided_clock_pin
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Level history of the pin; halves only compared after two quiet toggles
    logic pin_d;
    logic [20:0] run_len;
    logic [20:0] last_len;
    logic [1:0] quiet;

    // Half-period measurement; its quiet count is cleared by any bus write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_d <= 1'b0;
            run_len <= '0;
            last_len <= '0;
            quiet <= '0;
        end
        else
        begin
            pin_d <= divided_clock_pin;
            if (divided_clock_pin != pin_d)
            begin
                last_len <= run_len;
                run_len <= 21'h1;
                quiet <= s_axi_bvalid ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
            end
            else
            begin
                run_len <= run_len + 21'h1;
                if (s_axi_bvalid)
                    quiet <= 2'h0;
            end
        end
    end

    a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
        !divided_clock_pin && trim_switch == '0) else $error("outputs not idle in reset");
    a_first_toggle: assert property ($rose(aresetn) |->
        !divided_clock_pin [*5] ##[1:4] divided_clock_pin) else $error("first toggle off");
    a_equal_halves: assert property (divided_clock_pin != pin_d && quiet >= 2'h2
        |-> run_len == last_len) else $error("unequal half periods");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // xtc_trim_clkout_checker

bind xtc_trim_clkout xtc_trim_clkout_checker u_chk (.aclk, .aresetn, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .trim_switch, .divided_clock_pin);

// *** tb/test_xtc_trim_clkout.sv ***
`timescale 1ns/1ps
// ****************************************
// Self-checking bench for trim and clock output
// ****************************************
module test_xtc_trim_clkout;
    import xtc_pkg::*;
    // Design signals
    logic aclk, aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic divided_clock_pin;
    xtc_switch_type trim_switch;
    int n_errors = 0;
    int compares = 0;
    int n;
    // Half a millisecond of 40 ns cycles for the oscillator to settle
    localparam int SETTLE_CYCLES = 12500;

    xtc_trim_clkout DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trim_switch,
        .divided_clock_pin);

    // 25 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Verdict, reached from the main sequence or the watchdog
    task automatic wrap_up;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Byte address of a register index
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        check({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    // Read: data compared only when an OKAY answer is expected
    task automatic rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] ed);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        if (er === RESP_OKAY)
            check(s_axi_rdata, ed);
    endtask

    // Switches compared once the store has landed
    task automatic sw(input logic [4:0] c, input logic [3:0] f);
        repeat (2) @(posedge aclk);
        check({23'h0, trim_switch}, {23'h0, c, f});
    endtask

    // Length in cycles of the next whole half period
    task automatic half(output int len);
        logic p;
        p = divided_clock_pin;
        len = 0;
        while (divided_clock_pin === p) @(posedge aclk);
        p = divided_clock_pin;
        while (divided_clock_pin === p)
        begin
            @(posedge aclk);
            len++;
        end
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
    endtask

    // Write-only reads, refusals; bad writes must not store anything
    task automatic t_regs;
        logic [7:0] wo [7] = '{IDX_CLK_MODE, IDX_TRIM_MODE, IDX_DIV_LOW, IDX_DIV_MID,
            IDX_DIV_HIGH, IDX_TRIM_COARSE, IDX_TRIM_FINE};
        foreach (wo[i])
            rd(ad(wo[i]), RESP_OKAY, 32'h0);
        rd(ad(8'h40), RESP_SLVERR, 32'h0);
        wr(ad(IDX_TRIM_COARSE) + 32'h1, 8'h1f, RESP_SLVERR);
        wr(ad(IDX_STATUS), 8'h00, RESP_SLVERR);
        wr(ad(8'h40), 8'h00, RESP_SLVERR);
    endtask

    // Sleep, wake, gated and enabled trim updates along the trimming sequence
    task automatic t_trim;
        sw(5'h0, 4'h0);
        wr(ad(IDX_RUN_CTRL), 8'h01, RESP_OKAY);
        sw(RST_COARSE, RST_FINE);
        rd(ad(IDX_RUN_CTRL), RESP_OKAY, 32'h1);
        // Nominal sits one picofarad above reset, held back while trim is off
        wr(ad(IDX_TRIM_COARSE), 8'h11, RESP_OKAY);
        wr(ad(IDX_TRIM_MODE), 8'hef, RESP_OKAY);
        sw(RST_COARSE, RST_FINE);
        wr(ad(IDX_TRIM_MODE), 8'h10, RESP_OKAY);
        sw(5'h11, 4'h0);
        repeat (SETTLE_CYCLES) @(posedge aclk);
        wr(ad(IDX_TRIM_FINE), 8'h09, RESP_OKAY);
        sw(5'h11, 4'h9);
        wr(ad(IDX_RUN_CTRL), 8'h00, RESP_OKAY);
        sw(5'h11, 4'h9);
        wr(ad(IDX_RUN_CTRL), 8'h01, RESP_OKAY);
        wr(ad(IDX_TRIM_MODE), 8'h00, RESP_OKAY);
        wr(ad(IDX_TRIM_COARSE), 8'h03, RESP_OKAY);
        wr(ad(IDX_RUN_CTRL), 8'h00, RESP_OKAY);
        sw(5'h0, 4'h0);
        wr(ad(IDX_RUN_CTRL), 8'h01, RESP_OKAY);
        sw(5'h03, 4'h9);
    endtask

    // Divider factors, enable and disable
    task automatic t_clock;
        half(n);
        check(32'(n), 32'h7);
        wr(ad(IDX_DIV_LOW), 8'h01, RESP_OKAY);
        half(n);
        check(32'(n), 32'h1);
        wr(ad(IDX_DIV_LOW), 8'h03, RESP_OKAY);
        wr(ad(IDX_DIV_MID), 8'h01, RESP_OKAY);
        wr(ad(IDX_DIV_HIGH), 8'h10, RESP_OKAY);
        half(n);
        check(32'(n), 32'h103);
        wr(ad(IDX_CLK_MODE), 8'h00, RESP_OKAY);
        repeat (600) @(posedge aclk);
        check({31'h0, divided_clock_pin}, 32'h0);
        // Status: switches 03/9 in bits 10:2, pin low, run flag set
        rd(ad(IDX_STATUS), RESP_OKAY, 32'he5);
        wr(ad(IDX_CLK_MODE), 8'h40, RESP_OKAY);
        half(n);
        check(32'(n), 32'h103);
    endtask

    // Mid-run reset: defaults return, software loads its trim again
    task automatic t_rereset;
        do_reset();
        half(n);
        check(32'(n), 32'h7);
        wr(ad(IDX_RUN_CTRL), 8'h01, RESP_OKAY);
        sw(RST_COARSE, RST_FINE);
        wr(ad(IDX_TRIM_COARSE), 8'h03, RESP_OKAY);
        wr(ad(IDX_TRIM_FINE), 8'h09, RESP_OKAY);
        wr(ad(IDX_RUN_CTRL), 8'h00, RESP_OKAY);
        wr(ad(IDX_RUN_CTRL), 8'h01, RESP_OKAY);
        sw(5'h03, 4'h9);
    endtask

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        aresetn = 1'b0;
        s_axi_wstrb = 4'hf;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        // Response readies stay high, so every answer is taken at once
        {s_axi_bready, s_axi_rready} = 2'h3;
        do_reset();
        t_regs();
        t_trim();
        t_clock();
        t_rereset();
        wrap_up();
    end
endmodule // test_xtc_trim_clkout
